/* pkg/sacc_map.vh */
`ifndef SACC_MAP_VH
`define SACC_MAP_VH

// ==========================================================================
// Register byte offsets
`define SACC_OFF_CTRL        12'h000
`define SACC_OFF_CFG         12'h004
`define SACC_OFF_CHSEL       12'h008
`define SACC_OFF_PAIRCFG     12'h00c
`define SACC_OFF_RES_HI      12'h010
`define SACC_OFF_RES_LO      12'h014

// ==========================================================================
// Control register fields
`define SACC_CTRL_ENABLE     7
`define SACC_CTRL_TRACKMODE  6
`define SACC_CTRL_DONE       5
`define SACC_CTRL_BUSY       4
`define SACC_CTRL_STM_HI     3
`define SACC_CTRL_STM_LO     2
`define SACC_CTRL_LJUST      0

// ==========================================================================
// Configuration register fields
`define SACC_CFG_CLK_HI      7
`define SACC_CFG_CLK_LO      5
`define SACC_CFG_GAIN_HI     2
`define SACC_CFG_GAIN_LO     0

// ==========================================================================
// Start-mode codes
`define SACC_STM_SOFTWARE    2'h0
`define SACC_STM_TIMER3      2'h1
`define SACC_STM_EXTERNAL    2'h2
`define SACC_STM_TIMER2      2'h3

// ==========================================================================
// Reset values
`define SACC_RST_CTRL        8'h00
`define SACC_RST_CLKDIV      3'h3
`define SACC_RST_GAIN        3'h1
`define SACC_RST_CHSEL       4'h0
`define SACC_RST_PAIRCFG     4'h0

// ==========================================================================
// Timing counts in SAR clocks
`define SACC_TRACK_SAR_CLKS  2'h3

`endif

/* hdl/sacc_top.v */
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "sacc_map.vh"

module sacc_top #(
    parameter RES_BITS = 12
) (
    // Clock, reset, enable
    input  wire                clk_sys,
    input  wire                resetn,
    input  wire                ce,
    // APB slave
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [11:0]         paddr,
    input  wire [31:0]         pwdata,
    output wire                pready,
    output wire                pslverr,
    output reg  [31:0]         prdata,
    // Conversion triggers
    input  wire                timer3_ovf,
    input  wire                timer2_ovf,
    input  wire                external_convert_start,
    input  wire                chip_standby,
    // Analog front end
    input  wire                cmp_hi,
    output reg                 analog_power_on,
    output reg                 track_en,
    output reg  [3:0]          mux_pos_sel,
    output reg  [3:0]          mux_neg_sel,
    output reg                 mux_diff,
    output reg                 temp_sensor_sel,
    output reg  [2:0]          gain_amplifier,
    output reg  [RES_BITS-1:0] sar_trial,
    // Status
    output reg                 conversion_busy,
    output reg                 conversion_done_flag,
    output reg                 done_pulse
);

// ==========================================================================
// State codes
localparam [3:0] ST_IDLE  = 4'h1;
localparam [3:0] ST_TRACK = 4'h2;
localparam [3:0] ST_CONV  = 4'h4;
localparam [3:0] ST_DONE  = 4'h8;

// ==========================================================================
// Divider terminal count for a clock-period code
function [3:0] div_last;
    input [2:0] code;
    begin
        case (code)
            3'h0:    div_last = 4'h0;
            3'h1:    div_last = 4'h1;
            3'h2:    div_last = 4'h3;
            3'h3:    div_last = 4'h7;
            default: div_last = 4'hf;
        endcase
    end
endfunction

// ==========================================================================
// Registers
reg                converter_enable_r;
reg                track_mode_bit_r;
reg  [1:0]         start_mode_r;
reg                left_justify_bit_r;
reg  [2:0]         clock_period_field_r;
reg  [2:0]         gain_select_field_r;
reg  [3:0]         channel_select_r;
reg  [3:0]         pair_config_r;
reg  [RES_BITS-1:0] result_r;
reg                result_diff_r;
reg                err_r;
reg  [3:0]         state_r;
reg  [3:0]         state_nxt;
reg  [3:0]         div_cnt_r;
reg  [1:0]         track_cnt_r;
reg  [RES_BITS-1:0] sar_r;
reg  [RES_BITS-1:0] mask_r;
reg                conv_diff_r;
reg  [2:0]         ext_sync_r;
reg                ext_level_r;

wire               sar_tick;
wire               setup_ph;
wire               wr_acc;
wire               wr_ctrl;
wire               sw_start;
wire               trig;
wire               ext_rise;
wire               busy_fall;
wire               done_clr;
wire [7:0]         ctrl_rd;
wire [7:0]         cfg_rd;
wire [RES_BITS-1:0] sar_step;
reg  [7:0]         res_hi;
reg  [7:0]         res_lo;
reg                addr_ok;
reg  [31:0]        rd_mux;

// ==========================================================================
// APB decode
assign setup_ph = psel & ~penable;
assign pready   = psel & penable;
assign pslverr  = psel & penable & err_r;
assign wr_acc   = psel & penable & pwrite & ~err_r & ce;
assign wr_ctrl  = wr_acc & (paddr == `SACC_OFF_CTRL);

always @* begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    case (paddr)
        `SACC_OFF_CTRL:    rd_mux = {24'h00_0000, ctrl_rd};
        `SACC_OFF_CFG:     rd_mux = {24'h00_0000, cfg_rd};
        `SACC_OFF_CHSEL:   rd_mux = {28'h000_0000, channel_select_r};
        `SACC_OFF_PAIRCFG: rd_mux = {28'h000_0000, pair_config_r};
        `SACC_OFF_RES_HI:  rd_mux = {24'h00_0000, res_hi};
        `SACC_OFF_RES_LO:  rd_mux = {24'h00_0000, res_lo};
        default:           addr_ok = 1'b0;
    endcase
end

assign ctrl_rd = {converter_enable_r, track_mode_bit_r, conversion_done_flag,
                  conversion_busy, start_mode_r, 1'b0, left_justify_bit_r};
assign cfg_rd  = {clock_period_field_r, 2'h0, gain_select_field_r};

// Read data and error are captured in the setup cycle
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        prdata <= 32'h0000_0000;
        err_r  <= 1'b0;
    end else if (ce && setup_ph) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        err_r  <= ~addr_ok;
    end
end

// ==========================================================================
// Software-written configuration
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        converter_enable_r   <= 1'b0;
        track_mode_bit_r     <= 1'b0;
        start_mode_r         <= `SACC_STM_SOFTWARE;
        left_justify_bit_r   <= 1'b0;
        clock_period_field_r <= `SACC_RST_CLKDIV;
        gain_select_field_r  <= `SACC_RST_GAIN;
        channel_select_r     <= `SACC_RST_CHSEL;
        pair_config_r        <= `SACC_RST_PAIRCFG;
    end else if (wr_acc) begin
        case (paddr)
            `SACC_OFF_CTRL: begin
                converter_enable_r <= pwdata[`SACC_CTRL_ENABLE];
                track_mode_bit_r   <= pwdata[`SACC_CTRL_TRACKMODE];
                start_mode_r       <= pwdata[`SACC_CTRL_STM_HI:`SACC_CTRL_STM_LO];
                left_justify_bit_r <= pwdata[`SACC_CTRL_LJUST];
            end
            `SACC_OFF_CFG: begin
                clock_period_field_r <= pwdata[`SACC_CFG_CLK_HI:`SACC_CFG_CLK_LO];
                gain_select_field_r  <= pwdata[`SACC_CFG_GAIN_HI:`SACC_CFG_GAIN_LO];
            end
            `SACC_OFF_CHSEL:   channel_select_r <= pwdata[3:0];
            `SACC_OFF_PAIRCFG: pair_config_r    <= pwdata[3:0];
            default: ;
        endcase
    end
end

// ==========================================================================
// External start synchroniser and edge detect
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        ext_sync_r  <= 3'h0;
        ext_level_r <= 1'b0;
    end else if (ce) begin
        ext_sync_r <= {ext_sync_r[1:0], external_convert_start};
        if (ext_sync_r[2] == ext_sync_r[1])
            ext_level_r <= ext_sync_r[1];
    end
end

assign ext_rise = ext_sync_r[1] & ext_sync_r[2] & ~ext_level_r;

// ==========================================================================
// Trigger selection
assign sw_start = wr_ctrl & pwdata[`SACC_CTRL_BUSY] &
                  (pwdata[`SACC_CTRL_STM_HI:`SACC_CTRL_STM_LO] == `SACC_STM_SOFTWARE);
assign trig = converter_enable_r & (state_r == ST_IDLE) & (
              sw_start |
              ((start_mode_r == `SACC_STM_TIMER3) & timer3_ovf) |
              ((start_mode_r == `SACC_STM_EXTERNAL) & ext_rise) |
              ((start_mode_r == `SACC_STM_TIMER2) & timer2_ovf));

// ==========================================================================
// SAR clock divider
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        div_cnt_r <= 4'h0;
    end else if (ce) begin
        if (state_r == ST_IDLE || div_cnt_r >= div_last(clock_period_field_r))
            div_cnt_r <= 4'h0;
        else
            div_cnt_r <= div_cnt_r + 4'h1;
    end
end

assign sar_tick = (state_r != ST_IDLE) && (div_cnt_r >= div_last(clock_period_field_r));

// ==========================================================================
// Conversion sequencer
always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_IDLE: begin
            if (trig) begin
                if (track_mode_bit_r && start_mode_r != `SACC_STM_EXTERNAL)
                    state_nxt = ST_TRACK;
                else
                    state_nxt = ST_CONV;
            end
        end
        ST_TRACK: begin
            if (!converter_enable_r)
                state_nxt = ST_IDLE;
            else if (sar_tick && track_cnt_r == `SACC_TRACK_SAR_CLKS - 2'h1)
                state_nxt = ST_CONV;
        end
        ST_CONV: begin
            if (!converter_enable_r)
                state_nxt = ST_IDLE;
            else if (sar_tick && mask_r[0])
                state_nxt = ST_DONE;
        end
        ST_DONE:  state_nxt = ST_IDLE;
        default:  state_nxt = ST_IDLE;
    endcase
end

assign sar_step = (cmp_hi ? sar_r : (sar_r & ~mask_r)) | (mask_r >> 1);

always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        state_r     <= ST_IDLE;
        track_cnt_r <= 2'h0;
        sar_r       <= {RES_BITS{1'b0}};
        mask_r      <= {RES_BITS{1'b0}};
        conv_diff_r <= 1'b0;
        sar_trial   <= {RES_BITS{1'b0}};
    end else if (ce) begin
        state_r <= state_nxt;
        if (state_r == ST_IDLE) begin
            track_cnt_r <= 2'h0;
            conv_diff_r <= mux_diff;
        end else if (state_r == ST_TRACK && sar_tick) begin
            track_cnt_r <= track_cnt_r + 2'h1;
        end
        if (state_r != ST_CONV && state_nxt == ST_CONV) begin
            sar_r     <= {1'b1, {(RES_BITS-1){1'b0}}};
            mask_r    <= {1'b1, {(RES_BITS-1){1'b0}}};
            sar_trial <= {1'b1, {(RES_BITS-1){1'b0}}};
        end else if (state_r == ST_CONV && sar_tick) begin
            sar_r     <= sar_step;
            mask_r    <= mask_r >> 1;
            sar_trial <= mask_r[0] ? {RES_BITS{1'b0}} : sar_step;
        end else if (state_nxt != ST_CONV) begin
            sar_trial <= {RES_BITS{1'b0}};
        end
    end
end

// ==========================================================================
// Result capture and justification
assign busy_fall = (state_r == ST_DONE);

always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        result_r      <= {RES_BITS{1'b0}};
        result_diff_r <= 1'b0;
    end else if (ce && busy_fall) begin
        // Offset binary to two's complement by flipping the sign bit
        result_r      <= conv_diff_r ? (sar_r ^ {1'b1, {(RES_BITS-1){1'b0}}})
                                     : sar_r;
        result_diff_r <= conv_diff_r;
    end
end

always @* begin
    if (left_justify_bit_r) begin
        res_hi = result_r[11:4];
        res_lo = {result_r[3:0], 4'h0};
    end else begin
        res_hi = {{4{result_diff_r & result_r[11]}}, result_r[11:8]};
        res_lo = result_r[7:0];
    end
end

// ==========================================================================
// Busy and done flag
assign done_clr = wr_ctrl & ~pwdata[`SACC_CTRL_DONE];

always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        conversion_busy      <= 1'b0;
        conversion_done_flag <= 1'b0;
        done_pulse           <= 1'b0;
    end else if (ce) begin
        conversion_busy <= (state_nxt == ST_TRACK) || (state_nxt == ST_CONV);
        done_pulse      <= busy_fall;
        if (busy_fall)
            conversion_done_flag <= 1'b1;
        else if (done_clr)
            conversion_done_flag <= 1'b0;
    end
end

// ==========================================================================
// Multiplexer, gain and track-and-hold outputs
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        analog_power_on <= 1'b0;
        track_en        <= 1'b0;
        mux_pos_sel     <= 4'h0;
        mux_neg_sel     <= 4'h0;
        mux_diff        <= 1'b0;
        temp_sensor_sel <= 1'b0;
        gain_amplifier  <= `SACC_RST_GAIN;
    end else if (ce) begin
        analog_power_on <= converter_enable_r;
        gain_amplifier  <= gain_select_field_r;
        temp_sensor_sel <= channel_select_r[3];
        if (channel_select_r[3]) begin
            mux_diff    <= 1'b0;
            mux_pos_sel <= 4'h8;
            mux_neg_sel <= 4'h8;
        end else if (pair_config_r[channel_select_r[2:1]]) begin
            mux_diff    <= 1'b1;
            mux_pos_sel <= {1'b0, channel_select_r[2:1], 1'b0};
            mux_neg_sel <= {1'b0, channel_select_r[2:1], 1'b1};
        end else begin
            mux_diff    <= 1'b0;
            mux_pos_sel <= channel_select_r;
            mux_neg_sel <= channel_select_r;
        end
        if (!converter_enable_r || chip_standby)
            track_en <= 1'b0;
        else if (!track_mode_bit_r)
            track_en <= (state_nxt == ST_IDLE);
        else if (start_mode_r == `SACC_STM_EXTERNAL)
            track_en <= (state_nxt == ST_IDLE) & ~ext_level_r;
        else
            track_en <= (state_nxt == ST_TRACK);
    end
end

endmodule // sacc_top

/* test/sacc_top_asserts.sv */
`timescale 1ns/10ps
module sacc_top_asserts #(
    parameter RES_BITS = 12
) (
    // Clock, reset, enable
    input wire                clk_sys, resetn, ce,
    // APB
    input wire                psel, penable, pwrite, pready, pslverr,
    input wire [11:0]         paddr,
    input wire [31:0]         pwdata, prdata,
    // Triggers and comparator
    input wire                timer3_ovf, timer2_ovf, external_convert_start, chip_standby, cmp_hi,
    // Front end
    input wire                analog_power_on, track_en, mux_diff, temp_sensor_sel,
    input wire [3:0]          mux_pos_sel, mux_neg_sel,
    input wire [2:0]          gain_amplifier,
    input wire [RES_BITS-1:0] sar_trial,
    // Status
    input wire                conversion_busy, conversion_done_flag, done_pulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ======================================================================
    // Assertions
    apb_ready_a: assert property (pready == (psel && penable))
        else $error("pready differs from access phase");
    busy_done_a: assert property ($fell(conversion_busy) |-> ##[0:2] done_pulse)
        else $error("no done pulse after busy fell");
    pulse_flag_a: assert property (done_pulse |-> conversion_done_flag)
        else $error("done pulse without flag");
    pulse_after_a: assert property (done_pulse |-> !conversion_busy &&
        ($past(conversion_busy) || $past(conversion_busy, 2) || $past(conversion_busy, 3)))
        else $error("done pulse not after busy");
    busy_power_a: assert property (conversion_busy && $past(conversion_busy) |-> analog_power_on)
        else $error("busy while powered down");
    power_track_a: assert property (!analog_power_on && !$past(analog_power_on) |-> !track_en)
        else $error("tracking while powered down");
    idle_trial_a: assert property (!conversion_busy && !$past(conversion_busy)
        && !$past(conversion_busy, 2) |-> sar_trial == 0)
        else $error("trial code outside conversion");
    standby_track_a: assert property (chip_standby [*2] |-> !track_en)
        else $error("tracking in standby");
    single_mux_a: assert property (!mux_diff |-> mux_neg_sel == mux_pos_sel)
        else $error("single-ended legs differ");
    diff_mux_a: assert property (mux_diff |-> !mux_pos_sel[0]
        && mux_neg_sel == mux_pos_sel + 4'h1 && !temp_sensor_sel)
        else $error("bad differential pair");
    sensor_mux_a: assert property (temp_sensor_sel |-> mux_pos_sel == 4'h8 && !mux_diff)
        else $error("sensor channel index wrong");
    start_cause_a: assert property ($rose(conversion_busy) |-> $past(psel && penable && pwrite)
        || $past(timer3_ovf) || $past(timer2_ovf) || $past(external_convert_start))
        else $error("conversion without trigger");
    // Main scenarios
    cover property ($fell(conversion_busy));
    cover property (mux_diff && conversion_busy);
    cover property (temp_sensor_sel && conversion_busy);
endmodule // sacc_top_asserts

bind sacc_top sacc_top_asserts #(.RES_BITS(RES_BITS)) i_sacc_top_asserts (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .timer3_ovf(timer3_ovf), .timer2_ovf(timer2_ovf),
    .external_convert_start(external_convert_start), .chip_standby(chip_standby),
    .cmp_hi(cmp_hi), .analog_power_on(analog_power_on), .track_en(track_en),
    .mux_diff(mux_diff), .temp_sensor_sel(temp_sensor_sel), .mux_pos_sel(mux_pos_sel),
    .mux_neg_sel(mux_neg_sel), .gain_amplifier(gain_amplifier), .sar_trial(sar_trial),
    .conversion_busy(conversion_busy), .conversion_done_flag(conversion_done_flag),
    .done_pulse(done_pulse));

/* test/sacc_analog_model.sv */
`timescale 1ns/10ps
module sacc_analog_model (
    // Trial code and channel
    input  wire [11:0] sar_trial,
    input  wire [3:0]  mux_pos_sel,
    // Comparator
    output logic       cmp_hi
);
    logic [11:0] level;
    // Fixed level per channel, index 8 is the sensor
    assign level = 12'h3c7 + 12'h123 * {8'h00, mux_pos_sel};
    assign cmp_hi = (level >= sar_trial);
endmodule // sacc_analog_model

/* test/sacc_top_bench.sv */
`timescale 1ns/10ps
`include "sacc_map.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module sacc_top_bench;
    logic clk_sys = 0, resetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 0, sar_trial;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, timer3_ovf = 0, timer2_ovf = 0, external_convert_start = 0;
    logic chip_standby = 0, cmp_hi, analog_power_on, track_en, mux_diff, temp_sensor_sel;
    logic [3:0] mux_pos_sel, mux_neg_sel;
    logic [2:0] gain_amplifier;
    logic conversion_busy, conversion_done_flag, done_pulse;
    int errors = 0, compares = 0, ncyc, d[5];
    localparam [11:0] a_ctrl = `SACC_OFF_CTRL, a_cfg = `SACC_OFF_CFG, a_ch = `SACC_OFF_CHSEL;
    localparam [11:0] a_pair = `SACC_OFF_PAIRCFG, a_hi = `SACC_OFF_RES_HI, a_lo = `SACC_OFF_RES_LO;
    always #4 clk_sys = ~clk_sys;
    sacc_top i_sacc_top (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .timer3_ovf(timer3_ovf), .timer2_ovf(timer2_ovf),
        .external_convert_start(external_convert_start), .chip_standby(chip_standby),
        .cmp_hi(cmp_hi), .analog_power_on(analog_power_on), .track_en(track_en),
        .mux_pos_sel(mux_pos_sel), .mux_neg_sel(mux_neg_sel), .mux_diff(mux_diff),
        .temp_sensor_sel(temp_sensor_sel), .gain_amplifier(gain_amplifier),
        .sar_trial(sar_trial), .conversion_busy(conversion_busy),
        .conversion_done_flag(conversion_done_flag), .done_pulse(done_pulse));
    sacc_analog_model i_sacc_analog_model (.sar_trial(sar_trial), .mux_pos_sel(mux_pos_sel),
        .cmp_hi(cmp_hi));
    // ======================================================================
    // Shared tasks
    task final_report;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errors++;
            final_report();
        end
    endtask
    task wait_done;
        ncyc = 0;
        while (done_pulse !== 1'b1 && ncyc < 3000) begin
            @(negedge clk_sys);
            ncyc++;
        end
        if (ncyc >= 3000) begin
            errors++;
            final_report();
        end
        repeat (1250 - ncyc) @(negedge clk_sys);
    endtask
    task pulse(input logic t3);
        @(posedge clk_sys);
        if (t3) timer3_ovf <= 1'b1;
        else timer2_ovf <= 1'b1;
        @(posedge clk_sys);
        timer3_ovf <= 1'b0;
        timer2_ovf <= 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask
    // ======================================================================
    // Scenarios
    task t_reset;
        `CHK(gain_amplifier, 3'h1);
        `CHK(mux_diff, 1'b0);
        apb(0, a_cfg, 0);
        `CHK(rd, 32'h00000061);
        apb(0, a_pair, 0);
        `CHK(rd, 32'h00000000);
        apb(0, 12'h018, 0);
        `CHK({err, rd}, 33'h100000000);
    endtask
    task t_soft;
        apb(1, a_ch, 32'h3);
        apb(1, a_ctrl, 32'h80);
        repeat (3) @(negedge clk_sys);
        `CHK(track_en, 1'b1);
        apb(1, a_ctrl, 32'h90);
        repeat (3) @(negedge clk_sys);
        `CHK({conversion_busy, track_en}, 2'b10);
        wait_done();
        `CHK(conversion_done_flag, 1'b1);
        apb(0, a_hi, 0);
        `CHK(rd, 32'h07);
        apb(0, a_lo, 0);
        `CHK(rd, 32'h30);
        apb(0, a_ctrl, 0);
        `CHK(rd, 32'ha0);
        apb(1, a_ctrl, 32'h80);
        apb(0, a_ctrl, 0);
        `CHK(rd, 32'h80);
    endtask
    task t_diff;
        apb(1, a_pair, 32'h1);
        apb(1, a_ch, 32'h1);
        apb(1, a_ctrl, 32'h91);
        repeat (3) @(negedge clk_sys);
        `CHK({mux_diff, mux_pos_sel, mux_neg_sel}, 9'h101);
        wait_done();
        apb(0, a_hi, 0);
        `CHK(rd, 32'hbc);
        apb(0, a_lo, 0);
        `CHK(rd, 32'h70);
        apb(1, a_pair, 32'h0);
        apb(1, a_ctrl, 32'h90);
        repeat (3) @(negedge clk_sys);
        `CHK(mux_diff, 1'b0);
        wait_done();
        apb(0, a_lo, 0);
        `CHK(rd, 32'hea);
    endtask
    task t_sensor_clock;
        apb(1, a_ch, 32'h9);
        for (int k = 0; k < 6; k++) begin
            apb(1, a_cfg, {24'h0, 3'(k), 2'b00, 3'(k)});
            repeat (2) @(negedge clk_sys);
            `CHK(gain_amplifier, 3'(k));
            if (k < 5) begin
                apb(1, a_ctrl, 32'h90);
                wait_done();
                d[k] = ncyc;
                apb(0, a_lo, 32'h0);
                `CHK(rd, 32'hdf);
                `CHK(d[k] >= d[0] + 11 * ((1 << k) - 1) && d[k] <= d[0] + 13 * ((1 << k) - 1) + 2,
                    1'b1);
            end
        end
        `CHK(d[0] <= 20, 1'b1);
        `CHK({temp_sensor_sel, mux_pos_sel}, 5'h18);
        apb(0, a_lo, 0);
        `CHK(rd, 32'hdf);
        apb(1, a_cfg, 32'h61);
    endtask
    task t_timers;
        apb(1, a_ctrl, 32'h84);
        pulse(0);
        `CHK(conversion_busy, 1'b0);
        pulse(1);
        `CHK(conversion_busy, 1'b1);
        wait_done();
        apb(1, a_ctrl, 32'h8c);
        pulse(1);
        `CHK(conversion_busy, 1'b0);
        pulse(0);
        `CHK(conversion_busy, 1'b1);
        wait_done();
        apb(1, a_ctrl, 32'h0c);
        pulse(0);
        `CHK({conversion_busy, analog_power_on, track_en}, 3'b000);
        apb(1, a_ctrl, 32'hcc);
        repeat (3) @(negedge clk_sys);
        `CHK(track_en, 1'b0);
        pulse(0);
        ncyc = 3;
        while (track_en === 1'b1 && ncyc < 40) begin
            @(negedge clk_sys);
            ncyc++;
        end
        `CHK(ncyc >= 22 && ncyc <= 27, 1'b1);
        wait_done();
    endtask
    task t_ext;
        apb(1, a_ctrl, 32'hc8);
        repeat (6) @(negedge clk_sys);
        `CHK({track_en, conversion_busy}, 2'b10);
        @(posedge clk_sys);
        external_convert_start <= 1'b1;
        repeat (8) @(negedge clk_sys);
        `CHK({track_en, conversion_busy}, 2'b01);
        wait_done();
        repeat (3) @(negedge clk_sys);
        `CHK(track_en, 1'b0);
        @(posedge clk_sys);
        external_convert_start <= 1'b0;
        repeat (6) @(negedge clk_sys);
        `CHK(track_en, 1'b1);
        @(posedge clk_sys);
        chip_standby <= 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK(track_en, 1'b0);
        @(posedge clk_sys);
        chip_standby <= 1'b0;
        @(posedge clk_sys);
        ce <= 1'b0;
        apb(1, a_ch, 32'h5);
        ce <= 1'b1;
        apb(0, a_ch, 32'h0);
        `CHK(rd, 32'h9);
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        @(negedge clk_sys);
        t_reset();
        t_soft();
        t_diff();
        t_sensor_clock();
        t_timers();
        t_ext();
        final_report();
    end
endmodule // sacc_top_bench
